/* File: shared/gpt_consts.svh */
// Constants of the three-timer module: register offsets, fields, resets
// Assumes inclusion by bare name from the design files
`ifndef GPT_CONSTS_SVH
`define GPT_CONSTS_SVH
`define GPT_ADDR_W        4
`define GPT_OFF_CORE_CTRL 4'h0
`define GPT_OFF_CORE_CNT  4'h1
`define GPT_OFF_AUXA_CTRL 4'h2
`define GPT_OFF_AUXA_CNT  4'h3
`define GPT_OFF_AUXB_CTRL 4'h4
`define GPT_OFF_AUXB_CNT  4'h5
`define GPT_OFF_IRQ_STAT  4'h6
`define GPT_OFF_IRQ_CLR   4'h7
`define GPT_OFF_IRQ_EN    4'h8
`define GPT_OFF_TOGGLE    4'h9
// Control word fields
`define GPT_F_PRESC_LSB   0
`define GPT_F_MODE_LSB    3
`define GPT_F_RUN         5
`define GPT_F_DIR         6
`define GPT_F_EXT_DIR_EN  7
`define GPT_F_EDGE_LSB    8
`define GPT_F_AUX_FN_LSB  10
`define GPT_F_CLK_LATCH   12
`define GPT_F_RLD_EDGE_LSB 13
`define GPT_F_TOG_OUT_EN  15
`define GPT_CTRL_RESET    16'h0000
`define GPT_CNT_RESET     16'h0000
// Prescaler factor is 2**(3 + code)
`define GPT_PRESC_BASE_LOG 3
`define GPT_PRESC_W       10
`endif

/* File: shared/gpt_pkg.sv */
// Types shared by the three-timer module
// Assumes gpt_consts.svh is on the include path
package gpt_pkg;
  typedef enum logic [1:0] {
    GPT_MODE_TIMER = 2'b00,
    GPT_MODE_GATED = 2'b01,
    GPT_MODE_COUNT = 2'b10,
    GPT_MODE_INCR  = 2'b11
  } gpt_mode_t;
  typedef enum logic [1:0] {
    GPT_AUX_NORMAL  = 2'b00,
    GPT_AUX_CAPTURE = 2'b01,
    GPT_AUX_RELOAD  = 2'b10
  } gpt_aux_fn_t;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } gpt_bus_req_t;
  typedef struct packed {
    logic in_pin;
    logic dir_pin;
  } gpt_pins_t;
endpackage

/* File: design/gpt_counter.sv */
// One 16-bit up/down counter with mode, edge and quadrature decoding
// Assumes pins already synchronised and a shared prescaler tick vector
`timescale 1ns/1ps
`default_nettype none
`include "gpt_consts.svh"
module gpt_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [15:0]      ctrl,
  input  wire logic [7:0]       presc_ticks,
  input  wire logic             in_now,
  input  wire logic             in_prev,
  input  wire logic             dir_now,
  input  wire logic             dir_prev,
  input  wire logic             ext_tick,
  input  wire logic             hold,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  output logic      [WIDTH-1:0] count,
  output logic                  wrap
);
  import gpt_pkg::*;
  // Refuse widths that the wrap and step logic cannot serve
  if (WIDTH < 2) begin : g_bad_width
    $error("gpt_counter: WIDTH too small");
  end
  gpt_mode_t  mode;
  logic       step;
  logic       down;
  logic       in_rise;
  logic       in_fall;
  logic       quad_any;
  logic [1:0] edge_sel;
  // Select count event and direction from the mode
  always_comb begin
    mode     = gpt_mode_t'(ctrl[`GPT_F_MODE_LSB +: 2]);
    edge_sel = ctrl[`GPT_F_EDGE_LSB +: 2];
    in_rise  = in_now & ~in_prev;
    in_fall  = ~in_now & in_prev;
    quad_any = (in_now ^ in_prev) | (dir_now ^ dir_prev);
    down     = ctrl[`GPT_F_DIR] ^ (ctrl[`GPT_F_EXT_DIR_EN] & dir_now);
    step     = 1'b0;
    case (mode)
      GPT_MODE_TIMER: step = presc_ticks[ctrl[`GPT_F_PRESC_LSB +: 3]];
      GPT_MODE_GATED: step = presc_ticks[ctrl[`GPT_F_PRESC_LSB +: 3]] & in_now;
      GPT_MODE_COUNT: begin
        // Pin edges or the toggle latch when chained
        if (ctrl[`GPT_F_CLK_LATCH]) begin
          step = ext_tick;
        end else begin
          case (edge_sel)
            2'b01:   step = in_rise;
            2'b10:   step = in_fall;
            2'b11:   step = in_rise | in_fall;
            default: step = 1'b0;
          endcase
        end
      end
      GPT_MODE_INCR: begin
        // Quadrature: A leads B means up
        step = quad_any;
        down = ((in_now ^ in_prev) ? ~(in_now ^ dir_now) : (in_now ^ dir_now))
               ^ ctrl[`GPT_F_DIR];
      end
      default: step = 1'b0;
    endcase
    if (!ctrl[`GPT_F_RUN] || hold) begin
      step = 1'b0;
    end
  end
  // Count register with load priority
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= '0;
      wrap  <= 1'b0;
    end else if (load) begin
      count <= load_val;
      wrap  <= 1'b0;
    end else if (step) begin
      count <= down ? count - 1'b1 : count + 1'b1;
      wrap  <= down ? (count == '0) : (count == '1);
    end else begin
      wrap  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: design/gpt_triple_timer.sv */
// Three-timer module: core timer, two auxiliary timers, register port
// Assumes bus synchronous to ref_clk; pins resynchronised here
`timescale 1ns/1ps
`default_nettype none
`include "gpt_consts.svh"
// Function
// - Three independent 16-bit up/down counters, each with own configuration.
// - Each timer selects timer, gated, counter or incremental interface mode.
// - Timer mode counts CPU clock divided by 8 up to 1024, 3-bit code.
// - Counter mode advances on external input pin events.
// - Gated mode counts prescaled ticks only while the gate pin is high.
// - Each timer has one input pin: gate or count clock.
// - Direction set by software, optionally flipped by an external direction pin.
// - Incremental mode decodes quadrature A and B into count and direction.
// - Core toggle latch inverts on every core overflow or underflow.
// - Core toggle latch can drive an output pin.
// - Core toggle latch can clock either auxiliary timer for concatenation.
// - Auxiliary timers used for capture or reload do not count.
// - Capture mode copies core count on an auxiliary input pin edge.
// - Reload mode loads core from auxiliary on pin edge or latch transition.
// - Both auxiliaries reloading on opposite latch edges yields continuous PWM.
module gpt_triple_timer (
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  wire gpt_pkg::gpt_bus_req_t bus_req,
  input  wire gpt_pkg::gpt_pins_t    core_pins,
  input  wire gpt_pkg::gpt_pins_t    aux_a_pins,
  input  wire gpt_pkg::gpt_pins_t    aux_b_pins,
  output logic [15:0]        rdata,
  output logic               toggle_output_pin,
  output logic               irq
);
  import gpt_pkg::*;
  localparam int NT = 3; // 0 core, 1 aux a, 2 aux b

  logic [15:0]         ctrl [NT];
  logic [15:0]         cnt  [NT];
  logic [NT-1:0]       wrap;
  logic [NT-1:0]       load;
  logic [15:0]         load_val [NT];
  logic [NT-1:0]       hold;
  logic [NT-1:0]       in_s1, in_s2, in_s3;
  logic [NT-1:0]       dir_s1, dir_s2, dir_s3;
  logic [`GPT_PRESC_W-1:0] presc;
  logic [`GPT_PRESC_W-1:0] next_presc;
  logic [7:0]          presc_ticks;
  logic                core_toggle_latch;
  logic                latch_rise, latch_fall;
  logic [NT-1:0]       irq_stat, irq_en, clr_hit;
  logic [NT-1:0]       pin_in, pin_dir;
  logic                wr_hit [NT];
  logic [1:0]          aux_fn [NT];

  assign pin_in  = {aux_b_pins.in_pin,  aux_a_pins.in_pin,  core_pins.in_pin};
  assign pin_dir = {aux_b_pins.dir_pin, aux_a_pins.dir_pin, core_pins.dir_pin};

  // Two-flop synchronisers plus a history stage for edge detection
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      in_s1  <= '0;
      in_s2  <= '0;
      in_s3  <= '0;
      dir_s1 <= '0;
      dir_s2 <= '0;
      dir_s3 <= '0;
    end else begin
      in_s1  <= pin_in;
      in_s2  <= in_s1;
      in_s3  <= in_s2;
      dir_s1 <= pin_dir;
      dir_s2 <= dir_s1;
      dir_s3 <= dir_s2;
    end
  end

  // Free-running prescaler shared by all timers
  assign next_presc = presc + 1'b1;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      presc <= '0;
    end else begin
      presc <= next_presc;
    end
  end

  // One tick every 2**(3+k) cycles for code k
  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_tick
      localparam int LOGF = `GPT_PRESC_BASE_LOG + k;
      assign presc_ticks[k] = (presc[LOGF-1:0] == '1);
    end
  endgenerate

  // Auxiliary function fields
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      aux_fn[i] = (i == 0) ? 2'b00 : ctrl[i][`GPT_F_AUX_FN_LSB +: 2];
      hold[i]   = (aux_fn[i] != GPT_AUX_NORMAL);
    end
  end

  // Toggle latch transitions
  logic latch_d;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latch_d <= 1'b0;
    end else begin
      latch_d <= core_toggle_latch;
    end
  end
  assign latch_rise = core_toggle_latch & ~latch_d;
  assign latch_fall = ~core_toggle_latch & latch_d;

  // Reload and capture triggers for each auxiliary timer
  logic [NT-1:0] aux_pin_evt;
  logic [NT-1:0] rld_trig;
  logic [NT-1:0] cap_trig;
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      case (ctrl[i][`GPT_F_EDGE_LSB +: 2])
        2'b01:   aux_pin_evt[i] = in_s2[i] & ~in_s3[i];
        2'b10:   aux_pin_evt[i] = ~in_s2[i] & in_s3[i];
        2'b11:   aux_pin_evt[i] = in_s2[i] ^ in_s3[i];
        default: aux_pin_evt[i] = 1'b0;
      endcase
      cap_trig[i] = (i != 0) && aux_fn[i] == GPT_AUX_CAPTURE && aux_pin_evt[i];
      // Reload on pin edge or chosen latch edge: 01 rise, 10 fall
      rld_trig[i] = (i != 0) && aux_fn[i] == GPT_AUX_RELOAD &&
                    (aux_pin_evt[i] ||
                     (ctrl[i][`GPT_F_RLD_EDGE_LSB] && latch_rise) ||
                     (ctrl[i][`GPT_F_RLD_EDGE_LSB + 1] && latch_fall));
    end
  end

  // Load sources: bus write, capture into aux, reload into core
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      wr_hit[i]   = bus_req.wr &&
                    bus_req.addr == (`GPT_OFF_CORE_CNT + 4'(2 * i));
      load[i]     = wr_hit[i] || cap_trig[i];
      load_val[i] = wr_hit[i] ? bus_req.wdata : cnt[0];
    end
    // Aux b wins over aux a if both fire in one cycle
    if (!wr_hit[0] && (rld_trig[1] || rld_trig[2])) begin
      load[0]     = 1'b1;
      load_val[0] = rld_trig[2] ? cnt[2] : cnt[1];
    end
  end

  // The three counters, chained by the latch
  generate
    for (k = 0; k < NT; k++) begin : g_tmr
      gpt_counter #(.WIDTH(16)) u_cnt (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .ctrl        (ctrl[k]),
        .presc_ticks (presc_ticks),
        .in_now      (in_s2[k]),
        .in_prev     (in_s3[k]),
        .dir_now     (dir_s2[k]),
        .dir_prev    (dir_s3[k]),
        .ext_tick    ((k != 0) && (latch_rise | latch_fall)),
        .hold        (hold[k]),
        .load        (load[k]),
        .load_val    (load_val[k]),
        .count       (cnt[k]),
        .wrap        (wrap[k])
      );
    end
  endgenerate

  // Toggle latch inverts on core wrap; software may set its level
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      core_toggle_latch <= 1'b0;
    end else if (wrap[0]) begin
      core_toggle_latch <= ~core_toggle_latch;
    end else if (bus_req.wr && bus_req.addr == `GPT_OFF_TOGGLE) begin
      core_toggle_latch <= bus_req.wdata[0];
    end
  end

  // Latch onto the pin when enabled
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      toggle_output_pin <= 1'b0;
    end else begin
      toggle_output_pin <= ctrl[0][`GPT_F_TOG_OUT_EN] & core_toggle_latch;
    end
  end

  // Control registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < NT; i++) begin
        ctrl[i] <= `GPT_CTRL_RESET;
      end
    end else if (bus_req.wr) begin
      for (int i = 0; i < NT; i++) begin
        if (bus_req.addr == (`GPT_OFF_CORE_CTRL + 4'(2 * i))) begin
          ctrl[i] <= bus_req.wdata;
        end
      end
    end
  end

  // Sticky flags: set wins over clear
  assign clr_hit = (bus_req.wr && bus_req.addr == `GPT_OFF_IRQ_CLR) ?
                   bus_req.wdata[NT-1:0] : '0;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_stat <= '0;
      irq_en   <= '0;
    end else begin
      irq_stat <= (irq_stat & ~clr_hit) | wrap;
      if (bus_req.wr && bus_req.addr == `GPT_OFF_IRQ_EN) begin
        irq_en <= bus_req.wdata[NT-1:0];
      end
    end
  end

  // Level interrupt from a flop
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat & ~clr_hit) | wrap) & irq_en);
    end
  end

  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata <= '0;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `GPT_OFF_CORE_CTRL: rdata <= ctrl[0];
        `GPT_OFF_CORE_CNT:  rdata <= cnt[0];
        `GPT_OFF_AUXA_CTRL: rdata <= ctrl[1];
        `GPT_OFF_AUXA_CNT:  rdata <= cnt[1];
        `GPT_OFF_AUXB_CTRL: rdata <= ctrl[2];
        `GPT_OFF_AUXB_CNT:  rdata <= cnt[2];
        `GPT_OFF_IRQ_STAT:  rdata <= {13'h0000, irq_stat};
        `GPT_OFF_IRQ_EN:    rdata <= {13'h0000, irq_en};
        `GPT_OFF_TOGGLE:    rdata <= {15'h0000, core_toggle_latch};
        default:            rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

/* File: tb/gpt_triple_timer_properties.sv */
// Port-level assertions for the three-timer module
// Assumes bound to gpt_triple_timer; single clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module gpt_triple_timer_properties (
  input wire logic               ref_clk,
  input wire logic               reset,
  input wire gpt_pkg::gpt_bus_req_t bus_req,
  input wire gpt_pkg::gpt_pins_t core_pins,
  input wire gpt_pkg::gpt_pins_t aux_a_pins,
  input wire gpt_pkg::gpt_pins_t aux_b_pins,
  input wire logic [15:0]        rdata,
  input wire logic               toggle_output_pin,
  input wire logic               irq
);
  import gpt_pkg::*;
  logic [15:0] ctl_sh;
  logic [2:0]  en_sh;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Shadow copies of core control and interrupt enable
  always_ff @(posedge ref_clk) begin
    if (reset) ctl_sh <= 16'h0;
    else if (bus_req.wr && bus_req.addr == 4'h0) ctl_sh <= bus_req.wdata;
  end
  always_ff @(posedge ref_clk) begin
    if (reset) en_sh <= 3'h0;
    else if (bus_req.wr && bus_req.addr == 4'h8) en_sh <= bus_req.wdata[2:0];
  end
  AST_RD_IDLE: assert property (!bus_req.rd |=> rdata == 16'h0)
    else $error("read data not zero outside read answer");
  AST_UNMAP: assert property (bus_req.rd && bus_req.addr > 4'h9 |=> rdata == 16'h0)
    else $error("unmapped read not zero");
  AST_CLR_RD0: assert property (bus_req.rd && bus_req.addr == 4'h7 |=> rdata == 16'h0)
    else $error("clear register read not zero");
  AST_STAT_W: assert property (bus_req.rd && bus_req.addr == 4'h6 |=> rdata[15:3] == 13'h0)
    else $error("status upper bits set");
  AST_CTL_RB: assert property (bus_req.rd && bus_req.addr == 4'h0 |=> rdata == $past(ctl_sh))
    else $error("core control readback wrong");
  AST_EN_RB: assert property (bus_req.rd && bus_req.addr == 4'h8 |=> rdata[2:0] == $past(en_sh))
    else $error("enable readback wrong");
  AST_IRQ_EN: assert property (irq |-> $past(en_sh) != 3'h0)
    else $error("interrupt with no enable");
  AST_IRQ_OFF: assert property (bus_req.wr && bus_req.addr == 4'h8 && bus_req.wdata[2:0] == 3'h0
    |=> ##1 !irq)
    else $error("interrupt stays after masking");
  AST_TOG_EN: assert property (toggle_output_pin |-> $past(ctl_sh[15]))
    else $error("toggle pin driven while disabled");
endmodule
bind gpt_triple_timer gpt_triple_timer_properties u_props (.ref_clk(ref_clk), .reset(reset),
  .bus_req(bus_req), .core_pins(core_pins), .aux_a_pins(aux_a_pins),
  .aux_b_pins(aux_b_pins), .rdata(rdata), .toggle_output_pin(toggle_output_pin), .irq(irq));
`default_nettype wire

/* File: tb/gpt_pin_source.sv */
// Model of the external pin sources: event pulses, gate level, quadrature sensor
// Assumes one step every 8 cycles; levels change only after a clock edge
`timescale 1ns/1ps
`default_nettype none
module gpt_pin_source (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic [7:0] steps,
  input  wire logic       fwd,
  input  wire logic       quad,
  input  wire logic       gate_hi,
  input  wire logic       dir_lvl,
  output var gpt_pkg::gpt_pins_t pins,
  output logic            busy
);
  import gpt_pkg::*;
  logic [7:0] left;
  logic [2:0] sub;
  logic [1:0] ph;
  logic       pulse;
  // Step sequencer: pulse high 4 cycles, or one quadrature phase step
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      left <= 8'h0; sub <= 3'h0; ph <= 2'h0; pulse <= 1'b0;
    end else if (start) begin
      left <= steps; sub <= 3'h0;
    end else if (left != 8'h0) begin
      sub <= sub + 3'h1;
      if (sub == 3'h3) begin
        pulse <= !quad;
        if (quad) ph <= fwd ? ph + 2'h1 : ph - 2'h1;
      end
      if (sub == 3'h7) begin
        pulse <= 1'b0; left <= left - 8'h1;
      end
    end
  end
  // A leads B when moving forward
  assign pins.in_pin  = quad ? ph[1] ^ ph[0] : (pulse | gate_hi);
  assign pins.dir_pin = quad ? ph[1] : dir_lvl;
  assign busy = left != 8'h0;
endmodule
`default_nettype wire

/* File: tb/gpt_triple_timer_tb.sv */
// Self-checking bench for the three-timer module
// Assumes the package and the pin source model are compiled first
`timescale 1ns/1ps
`default_nettype none
module gpt_triple_timer_tb;
  import gpt_pkg::*;
  logic ref_clk, reset, start, fwd, quad, gate_hi, dir_lvl, busy, toggle_output_pin, irq;
  logic [7:0] steps;
  logic [15:0] rdata, v, a;
  gpt_bus_req_t bus_req;
  gpt_pins_t core_pins, aux_a_pins, aux_b_pins;
  int miscompares, n_checks;
  gpt_triple_timer dut (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req),
    .core_pins(core_pins), .aux_a_pins(aux_a_pins), .aux_b_pins(aux_b_pins),
    .rdata(rdata), .toggle_output_pin(toggle_output_pin), .irq(irq));
  gpt_pin_source u_src (.ref_clk(ref_clk), .reset(reset), .start(start), .steps(steps),
    .fwd(fwd), .quad(quad), .gate_hi(gate_hi), .dir_lvl(dir_lvl), .pins(core_pins),
    .busy(busy));
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Register port cycles
  task automatic wr(logic [3:0] ad, logic [15:0] d);
    @(posedge ref_clk); bus_req <= '{ad, d, 1'b1, 1'b0};
    @(posedge ref_clk); bus_req.wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] ad, output logic [15:0] d);
    @(posedge ref_clk); bus_req <= '{ad, 16'h0, 1'b0, 1'b1};
    @(posedge ref_clk); bus_req.rd <= 1'b0; #1 d = rdata;
  endtask
  // Count change over a window of per cycles
  task automatic rate(logic [15:0] ctl, int per, logic [15:0] dlt);
    wr(4'h0, ctl); rd(4'h1, a); cyc(per - 2); rd(4'h1, v);
    chk("count step", a + dlt, v);
  endtask
  // Run the pin source and wait for it to finish
  task automatic src(logic [7:0] n, logic q, logic f);
    int i;
    steps <= n; quad <= q; fwd <= f; start <= 1'b1;
    @(posedge ref_clk); start <= 1'b0; #1;
    for (i = 0; i < 3000 && busy !== 1'b0; i++) begin @(posedge ref_clk); #1; end
    if (i == 3000) begin
      miscompares++;
      close_out;
    end else begin
      cyc(6);
    end
  endtask
  task automatic pulse_a;
    aux_a_pins.in_pin <= 1'b1; cyc(4); aux_a_pins.in_pin <= 1'b0; cyc(8);
  endtask
  // Cycles the toggle pin stays at lvl, bounded at 1000
  task automatic hold_len(logic lvl, output logic [15:0] n);
    n = 16'h0;
    while (toggle_output_pin === lvl && n < 16'd1000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    reset = 1'b1; bus_req = '0; start = 0; fwd = 0; quad = 0; gate_hi = 0; dir_lvl = 0;
    steps = 8'h0; aux_a_pins = '0; aux_b_pins = '0; miscompares = 0; n_checks = 0;
    cyc(5); reset <= 1'b0;
    rd(4'h0, v); chk("ctrl reset", 16'h0, v);
    rd(4'hf, v); chk("unmapped", 16'h0, v);
    for (int c = 0; c < 8; c++) rate(16'h0020 | 16'(c), 16 << c, 16'h2);
    rate(16'h0060, 32, 16'hfffc);
    dir_lvl <= 1'b1; rate(16'h00e0, 32, 16'h4); dir_lvl <= 1'b0;
    rate(16'h0028, 32, 16'h0);
    gate_hi <= 1'b1; rate(16'h0028, 32, 16'h4); gate_hi <= 1'b0;
    for (int e = 1; e < 4; e++) begin
      wr(4'h0, 16'h0030 | 16'(e << 8)); wr(4'h1, 16'h0); src(8'd5, 1'b0, 1'b1);
      rd(4'h1, v); chk("events", e == 3 ? 16'd10 : 16'd5, v);
    end
    wr(4'h0, 16'h0038); wr(4'h1, 16'h0); src(8'd6, 1'b1, 1'b1);
    rd(4'h1, v); chk("quad fwd", 16'd6, v);
    src(8'd6, 1'b1, 1'b0); rd(4'h1, v); chk("quad back", 16'd0, v);
    wr(4'h8, 16'h1); wr(4'h1, 16'hfffe); wr(4'h0, 16'h8020); cyc(24); wr(4'h0, 16'h8000);
    rd(4'h6, v); chk("status", 16'h1, v);
    chk("irq", 16'h1, 16'(irq));
    rd(4'h9, v); chk("latch", 16'h1, v);
    chk("toggle pin", 16'h1, 16'(toggle_output_pin));
    wr(4'h8, 16'h0); cyc(2); #1 chk("irq masked", 16'h0, 16'(irq));
    wr(4'h7, 16'h1); rd(4'h6, v); chk("cleared", 16'h0, v);
    wr(4'h9, 16'h0); cyc(2); #1 chk("pin off", 16'h0, 16'(toggle_output_pin));
    wr(4'h1, 16'h1234); wr(4'h2, 16'h0520); pulse_a; cyc(32);
    rd(4'h3, v); chk("capture", 16'h1234, v);
    wr(4'h5, 16'h55aa); wr(4'h4, 16'h0920);
    aux_b_pins.in_pin <= 1'b1; cyc(4); aux_b_pins.in_pin <= 1'b0; cyc(8);
    rd(4'h1, v); chk("reload", 16'h55aa, v);
    // Aux b counts every latch change
    wr(4'h4, 16'h1030); wr(4'h5, 16'h0); wr(4'h9, 16'h1); wr(4'h9, 16'h0); cyc(2);
    rd(4'h5, v); chk("latch clock", 16'h2, v);
    // Latch-edge reloads: 8 ticks high, 24 ticks low at factor 8
    wr(4'h3, 16'hfff8); wr(4'h2, 16'h2800); wr(4'h5, 16'hffe8); wr(4'h4, 16'h4800);
    wr(4'h1, 16'hffff); wr(4'h0, 16'h8020); hold_len(1'b0, v);
    hold_len(1'b1, v); chk("pwm high", 16'd64, v);
    hold_len(1'b0, v); chk("pwm low", 16'd192, v);
    close_out;
  end
endmodule
`default_nettype wire
